/* File: power_ctrl_pkg.sv */
// shared constants and types for the halt and power-down controller
package power_ctrl_pkg;

  // stabilisation count is 2^17 on an 18-bit counter
  localparam int          STAB_CNT_W      = 18;
  localparam logic [17:0] STAB_CNT_LOAD   = 18'h20000;
  // least low time of the reset pin, in input clocks
  localparam logic [2:0]  RST_MIN_CYCLES  = 3'h6;
  // restart address after reset
  localparam logic [19:0] RESET_VECTOR    = 20'h00000;
  // io control register address and its peripheral-stop bit
  localparam logic [7:0]  IO_CTRL_ADDR    = 8'h3f;
  localparam int          IO_STOP_BIT     = 5;
  // processor control bits used to select standby and to enable its bus request exit
  localparam int          STBY_SEL_BIT    = 6;
  localparam int          STBY_CLR_BIT    = 3;
  localparam int          BREQ_EXIT_BIT   = 5;
  // register offsets on the avalon slave (byte addresses)
  localparam logic [3:0]  REG_CTRL_OFS    = 4'h0;
  localparam logic [3:0]  REG_IOCTL_OFS   = 4'h4;
  localparam logic [3:0]  REG_STATUS_OFS  = 4'h8;
  localparam logic [3:0]  REG_STABCNT_OFS = 4'hc;
  // reset values
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [7:0]  IOCTL_RST       = 8'h00;

  // power states, gray coded along halt/sleep/standby path
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_HALT    = 3'b001,
    ST_SLEEP   = 3'b011,
    ST_SYSSTOP = 3'b010,
    ST_STANDBY = 3'b110,
    ST_WAKE    = 3'b111,
    ST_BUSGNT  = 3'b101,
    ST_IOSTOP  = 3'b100
  } pwr_state_t;

  // wake request sources as seen by the controller
  typedef struct packed {
    logic nmi;      // non-maskable request
    logic irq;      // maskable request, already individually enabled
    logic ext_irq;  // external request, usable for standby exit
    logic bus_req;  // bus request from another master
  } wake_src_t;

  // clock gate enables for the two gated domains
  typedef struct packed {
    logic core_en;
    logic periph_en;
  } clk_gate_t;

endpackage

/* File: sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
  input  wire logic ref_clk,  // input clock
  input  wire logic rst,      // synchronous reset
  input  wire logic pin_in,   // asynchronous level
  output var  logic level_out // filtered level
);
  logic [2:0] sync_ff;      // stage chain
  logic [2:0] nxt_sync;
  logic       level_ff;     // accepted level
  logic       nxt_level;

  // shift chain and accept a change once stages two and three agree
  always_comb begin
    nxt_sync  = {sync_ff[1:0], pin_in};
    nxt_level = level_ff;
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_level = sync_ff[2];
    end
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_ff  <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      sync_ff  <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;
endmodule
`default_nettype wire

/* File: clk_gate.sv */
// glitch-free clock gate: enable latched while clock is low
`timescale 1ns/1ps
`default_nettype none
module clk_gate (
  input  wire logic clk_in,  // clock to gate
  input  wire logic en,      // enable, from clk_in domain
  output var  logic clk_out  // gated clock
);
  logic en_lat; // enable held stable while clock is high

  // transparent while clock low so enable never cuts a high phase
  always_latch begin
    if (!clk_in) begin
      en_lat = en;
    end
  end

  assign clk_out = clk_in & en_lat;
endmodule
`default_nettype wire

/* File: halt_and_power_down_control.sv */
// halt and power-down state controller with avalon-mm registers
// Operation
// - system clock is input clock halved
// - halt indicator low while halted
// - repeat dummy fetch of next opcode
// - only instruction execution stops in halt
// - reset held six cycles restarts at zero
// - unmasked interrupt ends halt
// - masked source keeps device halted
// - nmi ends halt regardless of enable
// - sleep stops core, peripherals run
// - io stop stops peripherals, core runs
// - system stop stops core and peripherals
// - standby also stops oscillator and clocks
// - wake counts 2^17 before acknowledge
// - early source drop returns to standby
// - bus request wakes only if enabled
// - grant bus, float outputs until released
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module halt_and_power_down_control (
  input  wire logic                   ref_clk,      // input clock
  input  wire logic                   rst,          // synchronous reset
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output var  logic [31:0]            avs_readdata,
  output var  logic                   avs_waitrequest,
  // core-side events
  input  wire logic                   halt_exec,    // halt instruction
  input  wire logic                   sleep_exec,   // sleep instruction
  input  wire logic                   global_interrupt_enable_flag,
  input  wire logic [19:0]            next_pc,      // address after halt
  input  wire logic                   reset_pin_n,  // external reset pin
  input  wire power_ctrl_pkg::wake_src_t wake_in,   // asynchronous sources
  // outputs
  output var  logic                   sys_clk,      // halved clock
  output var  logic                   core_clk,     // gated core clock
  output var  logic                   periph_clk,   // gated peripheral clk
  output var  logic                   osc_enable,   // oscillator run
  output var  logic                   halt_n,       // halt indicator
  output var  logic                   dummy_fetch,  // opcode fetch strobe
  output var  logic [19:0]            fetch_addr,   // fetch address
  output var  logic                   bus_drive_en, // addr/strobe enable
  output var  logic                   bus_grant_out,
  output var  logic                   wake_ack,     // interrupt ack
  output var  logic                   cpu_restart,  // reset sequence pulse
  output var  logic [19:0]            restart_addr  // restart address
);
  import power_ctrl_pkg::*;

  // pin synchronisers
  logic nmi_s, irq_s, ext_s, breq_s, rstpin_s;
  logic [4:0] raw_pins;
  logic [4:0] sync_pins;
  assign raw_pins = {wake_in.nmi, wake_in.irq, wake_in.ext_irq,
                     wake_in.bus_req, reset_pin_n};
  generate
    for (genvar gi = 0; gi < 5; gi++) begin : g_sync
      sync3 u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (raw_pins[gi]),
        .level_out (sync_pins[gi])
      );
    end
  endgenerate
  assign {nmi_s, irq_s, ext_s, breq_s, rstpin_s} = sync_pins;

  // system clock divider
  logic div_ff, nxt_div;
  always_comb begin
    nxt_div = ~div_ff;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // registers
  logic [7:0]  ctrl_ff, nxt_ctrl;    // processor control bits
  logic [7:0]  ioctl_ff, nxt_ioctl;  // io_control_register
  logic [31:0] rdata_ff, nxt_rdata;  // read data
  logic        ack_ff, nxt_ack;      // one-cycle wait then answer
  logic        bus_req_access;
  logic        bus_standby_exit;
  assign bus_standby_exit = ctrl_ff[BREQ_EXIT_BIT];

  // state
  pwr_state_t  state_ff, nxt_state;
  logic [17:0] stab_ff, nxt_stab;    // stabilisation counter
  logic [2:0]  rcnt_ff, nxt_rcnt;    // reset-low counter
  logic        wake_bus_ff, nxt_wake_bus; // waking for bus request
  logic        ack_pulse_ff, nxt_ack_pulse;
  logic        restart_ff, nxt_restart;
  logic        standby_sel;
  logic        halt_wake;
  logic        wake_src;

  // standby chosen when bit 6 set, bit 3 clear and peripherals stopped
  assign standby_sel = ctrl_ff[STBY_SEL_BIT] & ~ctrl_ff[STBY_CLR_BIT]
                       & ioctl_ff[IO_STOP_BIT];
  // nmi ignores the global flag, others need it
  assign halt_wake = nmi_s | (irq_s & global_interrupt_enable_flag);
  // source that may start or hold a standby wake
  assign wake_src = ext_s | (breq_s & bus_standby_exit);

  assign bus_req_access = avs_read | avs_write;

  // register file next state
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_ioctl = ioctl_ff;
    nxt_rdata = rdata_ff;
    nxt_ack   = 1'b0;
    if (bus_req_access && !ack_ff) begin
      nxt_ack = 1'b1;
    end
    // a write lands only on the edge that sees waitrequest low
    if (avs_write && ack_ff) begin
      case (avs_address)
        REG_CTRL_OFS:  nxt_ctrl  = avs_writedata[7:0];
        REG_IOCTL_OFS: nxt_ioctl = avs_writedata[7:0];
        default:       nxt_ctrl  = ctrl_ff;
      endcase
    end
    if (avs_read && !ack_ff) begin
      case (avs_address)
        REG_CTRL_OFS:    nxt_rdata = {24'h0, ctrl_ff};
        REG_IOCTL_OFS:   nxt_rdata = {24'h0, ioctl_ff};
        REG_STATUS_OFS:  nxt_rdata = {27'h0, wake_bus_ff,
                                      bus_grant_out, state_ff};
        REG_STABCNT_OFS: nxt_rdata = {14'h0, stab_ff};
        default:         nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff  <= CTRL_RST;
      ioctl_ff <= IOCTL_RST;
      rdata_ff <= 32'h0;
      ack_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      ioctl_ff <= nxt_ioctl;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
    end
  end

  assign avs_waitrequest = bus_req_access & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  // power state machine next values
  always_comb begin
    nxt_state     = state_ff;
    nxt_stab      = stab_ff;
    nxt_rcnt      = rcnt_ff;
    nxt_wake_bus  = wake_bus_ff;
    nxt_ack_pulse = 1'b0;
    nxt_restart   = 1'b0;
    // count reset-pin low time, saturating at the minimum
    if (!rstpin_s) begin
      if (rcnt_ff != RST_MIN_CYCLES) begin
        nxt_rcnt = rcnt_ff + 3'h1;
      end
    end else begin
      nxt_rcnt = 3'h0;
    end
    if (!rstpin_s && rcnt_ff == RST_MIN_CYCLES - 3'h1) begin
      nxt_state   = ST_RUN;
      nxt_restart = 1'b1;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (halt_exec) begin
            nxt_state = ST_HALT;
          end else if (sleep_exec) begin
            if (standby_sel) begin
              nxt_state = ST_STANDBY;
            end else if (ioctl_ff[IO_STOP_BIT]) begin
              nxt_state = ST_SYSSTOP;
            end else begin
              nxt_state = ST_SLEEP;
            end
          end else if (ioctl_ff[IO_STOP_BIT]) begin
            nxt_state = ST_IOSTOP;
          end
        end
        ST_IOSTOP: begin
          if (!ioctl_ff[IO_STOP_BIT]) begin
            nxt_state = ST_RUN;
          end else if (sleep_exec) begin
            nxt_state = standby_sel ? ST_STANDBY : ST_SYSSTOP;
          end
        end
        ST_HALT, ST_SLEEP, ST_SYSSTOP: begin
          if (halt_wake) begin
            nxt_state     = ST_RUN;
            nxt_ack_pulse = 1'b1;
          end // else stays put
        end
        ST_STANDBY: begin
          if (wake_src) begin
            nxt_state    = ST_WAKE;
            nxt_stab     = STAB_CNT_LOAD;
            nxt_wake_bus = ~ext_s;
          end
        end
        ST_WAKE: begin
          if (!wake_src) begin
            nxt_state = ST_STANDBY;
          end else if (stab_ff == 18'h00001) begin
            nxt_stab = 18'h0;
            if (wake_bus_ff) begin
              nxt_state = ST_BUSGNT;
            end else begin
              nxt_state     = ST_RUN;
              nxt_ack_pulse = 1'b1;
            end
          end else begin
            nxt_stab = stab_ff - 18'h1;
          end
        end
        ST_BUSGNT: begin
          if (!breq_s) begin
            nxt_state    = ST_RUN;
            nxt_wake_bus = 1'b0;
          end
        end
        default: nxt_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff     <= ST_RUN;
      stab_ff      <= 18'h0;
      rcnt_ff      <= 3'h0;
      wake_bus_ff  <= 1'b0;
      ack_pulse_ff <= 1'b0;
      restart_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      stab_ff      <= nxt_stab;
      rcnt_ff      <= nxt_rcnt;
      wake_bus_ff  <= nxt_wake_bus;
      ack_pulse_ff <= nxt_ack_pulse;
      restart_ff   <= nxt_restart;
    end
  end

  // clock gate enables from state
  clk_gate_t gate;
  always_comb begin
    gate.core_en   = !(state_ff inside {ST_SLEEP, ST_SYSSTOP,
                       ST_STANDBY, ST_WAKE, ST_BUSGNT});
    gate.periph_en = !(state_ff inside {ST_IOSTOP, ST_SYSSTOP,
                       ST_STANDBY, ST_WAKE});
  end

  // glitch-free gating of the halved clock
  clk_gate u_core_gate (
    .clk_in  (div_ff),
    .en      (gate.core_en),
    .clk_out (core_clk)
  );
  clk_gate u_periph_gate (
    .clk_in  (div_ff),
    .en      (gate.periph_en),
    .clk_out (periph_clk)
  );

  // halt keeps bus busy with the opcode after the halt instruction
  always_comb begin
    halt_n      = (state_ff != ST_HALT);
    dummy_fetch = (state_ff == ST_HALT) & div_ff;
    fetch_addr  = next_pc;
    // peripherals keep their clock in halt
    sys_clk     = div_ff & !(state_ff inside {ST_STANDBY, ST_WAKE});
    osc_enable  = (state_ff != ST_STANDBY);
  end

  assign bus_drive_en  = (state_ff != ST_BUSGNT);
  assign bus_grant_out = (state_ff == ST_BUSGNT);
  assign wake_ack      = ack_pulse_ff;
  assign cpu_restart   = restart_ff;
  assign restart_addr  = RESET_VECTOR;

  // assertions, all on the input clock and idle during reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_halt_low: assert property ((state_ff == ST_HALT) |-> !halt_n)
    else $error("halt indicator not low in halt");
  a_masked_stay: assert property (state_ff == ST_HALT && !nmi_s
    && !global_interrupt_enable_flag && rstpin_s |=> state_ff == ST_HALT)
    else $error("masked request left halt");
  a_nmi_exit: assert property (state_ff == ST_HALT && nmi_s
    && rstpin_s |=> state_ff == ST_RUN && wake_ack)
    else $error("nmi did not end halt");
  a_irq_exit: assert property (state_ff == ST_SLEEP && irq_s
    && global_interrupt_enable_flag && rstpin_s |=> state_ff == ST_RUN)
    else $error("enabled request did not end sleep");
  a_stab_load: assert property (state_ff == ST_STANDBY
    && wake_src && rstpin_s |=> stab_ff == STAB_CNT_LOAD)
    else $error("counter not reloaded on wake");
  a_early_drop: assert property (state_ff == ST_WAKE && !wake_src
    && rstpin_s |=> state_ff == ST_STANDBY)
    else $error("early drop did not return to standby");
  a_no_early_ack: assert property (state_ff == ST_WAKE
    && stab_ff > 18'h1 |=> !wake_ack)
    else $error("acknowledge before count done");
  a_bus_grant: assert property (bus_grant_out
    |-> !bus_drive_en && !gate.core_en)
    else $error("bus driven while granted");
  a_breq_gated: assert property (state_ff == ST_STANDBY && !ext_s
    && !bus_standby_exit && rstpin_s |=> state_ff == ST_STANDBY)
    else $error("bus request woke with exit disabled");
  a_reset_seq: assert property (!rstpin_s && rcnt_ff == 3'h5
    |=> cpu_restart && state_ff == ST_RUN)
    else $error("reset pin did not restart");
  a_sysstop_gate: assert property (state_ff == ST_SYSSTOP
    |-> !gate.core_en && !gate.periph_en)
    else $error("system stop left a clock on");
  c_halt_exit: cover property (state_ff == ST_HALT ##1 state_ff == ST_RUN);
  c_standby_wake: cover property (state_ff == ST_WAKE ##1 state_ff == ST_RUN);
  c_bus_grant: cover property (state_ff == ST_BUSGNT ##1 state_ff == ST_RUN);
  c_restandby: cover property (state_ff == ST_WAKE ##1 state_ff == ST_STANDBY);
endmodule
`default_nettype wire

/* File: wake_source_model.sv */
// model of the interrupt sources and the competing bus master
`timescale 1ns/1ps
`default_nettype none
module wake_source_model #(
  parameter int RST_LOW = 8              // pin reset low time, six or more
) (
  input  wire logic                      ref_clk,       // input clock
  input  wire power_ctrl_pkg::wake_src_t src_cmd,       // levels from bench
  input  wire logic                      pin_reset,     // starts a pin reset
  output var  power_ctrl_pkg::wake_src_t wake_in,       // levels to device
  output var  logic                      reset_pin_n    // reset pin
);
  import power_ctrl_pkg::*;
  int rst_cnt = 0;                       // low cycles left on the pin
  // sources move just after the edge and hold as long as asked
  always @(posedge ref_clk) begin
    wake_in <= src_cmd;
    if (pin_reset) begin
      rst_cnt <= RST_LOW;
    end else if (rst_cnt > 0) begin
      rst_cnt <= rst_cnt - 1;
    end
  end
  // pin low for the whole count, released high afterwards
  assign reset_pin_n = (rst_cnt == 0);
endmodule
`default_nettype wire

/* File: halt_and_power_down_control_tb.sv */
// self-checking bench for the halt and power-down controller
`timescale 1ns/1ps
`default_nettype none
module halt_and_power_down_control_tb;
  import power_ctrl_pkg::*;
  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;              // register byte address
  logic [31:0] avs_writedata, avs_readdata;
  logic        halt_exec, sleep_exec, gie, reset_pin_n, pin_reset;
  logic [19:0] next_pc, fetch_addr, restart_addr;
  wake_src_t   wake_in, src_cmd;         // source levels
  logic        sys_clk, core_clk, periph_clk, osc_enable, halt_n;
  logic        dummy_fetch, bus_drive_en, bus_grant_out, wake_ack;
  logic        cpu_restart;
  int          err_count = 0;
  int          compares = 0;
  int          sys_n = 0, core_n = 0, per_n = 0;  // clock edge counts
  int          ack_n = 0, rs_n = 0, df_n = 0;     // pulse counts

  halt_and_power_down_control DUT (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_exec(halt_exec),
    .sleep_exec(sleep_exec), .global_interrupt_enable_flag(gie),
    .next_pc(next_pc), .reset_pin_n(reset_pin_n), .wake_in(wake_in),
    .sys_clk(sys_clk), .core_clk(core_clk), .periph_clk(periph_clk),
    .osc_enable(osc_enable), .halt_n(halt_n), .dummy_fetch(dummy_fetch),
    .fetch_addr(fetch_addr), .bus_drive_en(bus_drive_en),
    .bus_grant_out(bus_grant_out), .wake_ack(wake_ack),
    .cpu_restart(cpu_restart), .restart_addr(restart_addr));

  wake_source_model src (
    .ref_clk(ref_clk), .src_cmd(src_cmd), .pin_reset(pin_reset),
    .wake_in(wake_in), .reset_pin_n(reset_pin_n));

  // clock and edge or pulse counters
  always #4 ref_clk = ~ref_clk;
  always @(posedge sys_clk) sys_n++;
  always @(posedge core_clk) core_n++;
  always @(posedge periph_clk) per_n++;
  always @(posedge ref_clk) begin
    if (wake_ack === 1'b1) ack_n++;
    if (cpu_restart === 1'b1) rs_n++;
    if (dummy_fetch === 1'b1) df_n++;
  end

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk_state(input pwr_state_t s);
    logic [31:0] q;
    bus_xfer(1'b0, REG_STATUS_OFS, 32'h0, q);
    check_val({29'h0, q[2:0]}, {29'h0, s});
  endtask

  // count clock edges over n input clock cycles
  task automatic clk_run(input int n, input int s, input int c, input int p);
    int s0, c0, p0;
    s0 = sys_n;
    c0 = core_n;
    p0 = per_n;
    repeat (n) @(posedge ref_clk);
    check_val(sys_n - s0, s);
    check_val(core_n - c0, c);
    check_val(per_n - p0, p);
  endtask

  task automatic wait_ack(input int lim);
    int a0;
    a0 = ack_n;
    for (int i = 0; i < lim && ack_n == a0; i++) @(posedge ref_clk);
    check_val(ack_n - a0, 1);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pulse(input logic slp);
    @(posedge ref_clk);
    if (slp) sleep_exec <= 1'b1;
    else halt_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    halt_exec <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // reset values, read back and an unmapped place
  task automatic t_regs;
    logic [31:0] q;
    bus_xfer(1'b0, REG_CTRL_OFS, 32'h0, q);
    check_val(q, {24'h0, CTRL_RST});
    bus_xfer(1'b0, REG_IOCTL_OFS, 32'h0, q);
    check_val(q, {24'h0, IOCTL_RST});
    bus_xfer(1'b1, REG_CTRL_OFS, 32'hffff_ff64, q);
    bus_xfer(1'b0, REG_CTRL_OFS, 32'h0, q);
    check_val(q, 32'h64);
    bus_xfer(1'b0, 4'h1, 32'h0, q);
    check_val(q, 32'h0);
    chk_state(ST_RUN);
    clk_run(16, 8, 8, 8);
  endtask

  // halt, masked request, nmi and enabled request
  task automatic t_halt;
    int a0;
    do_reset();
    next_pc <= 20'h12345;
    pulse(1'b0);
    check_val(halt_n, 1'b0);
    check_val(fetch_addr, 20'h12345);
    a0 = df_n;
    clk_run(16, 8, 8, 8);
    check_val(df_n > a0, 1'b1);
    src_cmd.irq <= 1'b1;
    a0 = ack_n;
    repeat (20) @(posedge ref_clk);
    check_val(ack_n - a0, 0);
    chk_state(ST_HALT);
    src_cmd.nmi <= 1'b1;
    wait_ack(20);
    check_val(halt_n, 1'b1);
    src_cmd <= '0;
    repeat (8) @(posedge ref_clk);                  // let the synced nmi fall
    pulse(1'b0);
    chk_state(ST_HALT);
    gie <= 1'b1;
    src_cmd.irq <= 1'b1;
    wait_ack(20);
    chk_state(ST_RUN);
    src_cmd <= '0;
    gie <= 1'b0;
  endtask

  // pin reset out of halt
  task automatic t_pinreset;
    int r0;
    pulse(1'b0);
    r0 = rs_n;
    pin_reset <= 1'b1;
    @(posedge ref_clk);
    pin_reset <= 1'b0;
    for (int i = 0; i < 40 && rs_n == r0; i++) @(posedge ref_clk);
    check_val(rs_n - r0, 1);
    check_val(restart_addr, RESET_VECTOR);
    check_val(halt_n, 1'b1);
  endtask

  // io stop, system stop and sleep clock gating
  task automatic t_modes;
    logic [31:0] q;
    do_reset();
    bus_xfer(1'b1, REG_IOCTL_OFS, 32'h20, q);
    chk_state(ST_IOSTOP);
    clk_run(16, 8, 8, 0);
    pulse(1'b1);
    chk_state(ST_SYSSTOP);
    clk_run(16, 8, 0, 0);
    do_reset();
    pulse(1'b1);
    chk_state(ST_SLEEP);
    clk_run(16, 8, 0, 8);
    gie <= 1'b1;
    src_cmd.irq <= 1'b1;
    wait_ack(20);
    chk_state(ST_RUN);
    src_cmd <= '0;
    gie <= 1'b0;
  endtask

  // standby entry, refused and dropped wakes, bus request wake
  task automatic t_standby;
    logic [31:0] q;
    int n;
    do_reset();
    bus_xfer(1'b1, REG_CTRL_OFS, 32'h40, q);
    bus_xfer(1'b1, REG_IOCTL_OFS, 32'h20, q);
    pulse(1'b1);
    chk_state(ST_STANDBY);
    check_val(osc_enable, 1'b0);
    clk_run(16, 0, 0, 0);
    src_cmd.bus_req <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk_state(ST_STANDBY);
    src_cmd <= 4'h2;                                // external request only
    repeat (40) @(posedge ref_clk);
    chk_state(ST_WAKE);
    check_val(osc_enable, 1'b1);
    clk_run(16, 0, 0, 0);
    src_cmd <= '0;
    repeat (10) @(posedge ref_clk);
    chk_state(ST_STANDBY);
    bus_xfer(1'b1, REG_CTRL_OFS, 32'h60, q);
    src_cmd.bus_req <= 1'b1;
    n = 0;
    repeat (40) @(posedge ref_clk);
    bus_xfer(1'b0, REG_STABCNT_OFS, 32'h0, q);
    check_val(q > 32'h1ff00 && q < 32'h20000, 1'b1);
    while (bus_grant_out !== 1'b1 && n < 140000) begin
      @(posedge ref_clk);
      n++;
    end
    check_val(n > 131000 && n <= 131072, 1'b1);
    check_val(bus_drive_en, 1'b0);
    check_val(osc_enable, 1'b1);
    src_cmd <= '0;
    repeat (20) @(posedge ref_clk);
    check_val({bus_grant_out, bus_drive_en}, 2'b01);
    // io stop bit is still set, so the device settles in io stop
    chk_state(ST_IOSTOP);
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    halt_exec = 1'b0;
    sleep_exec = 1'b0;
    gie = 1'b0;
    next_pc = '0;
    src_cmd = '0;
    pin_reset = 1'b0;
    do_reset();
    t_regs();
    t_halt();
    t_pinreset();
    t_modes();
    t_standby();
    print_verdict();
  end

  // watchdog: the 2^17-cycle wake plus about 15 percent margin
  initial begin
    #1200000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
